/* verilog/sil_cfg.svh */
// constants of the strap input latch: offsets, fields, resets, timing
`ifndef SIL_CFG_SVH
`define SIL_CFG_SVH

// --------------------------------------------------------------------
// register offsets (byte addresses)
// --------------------------------------------------------------------
`define SIL_OFS_STATUS      8'h00
`define SIL_OFS_CTRL        8'h04
`define SIL_OFS_MODE        8'h08

// --------------------------------------------------------------------
// status register fields
// --------------------------------------------------------------------
`define SIL_ST_ADDR_LSB     0
`define SIL_ST_BCAST_BIT    5
`define SIL_ST_MODE_LSB     6
`define SIL_ST_REFCLK_BIT   10
`define SIL_ST_LED_BIT      11
`define SIL_ST_DONE_BIT     31

// --------------------------------------------------------------------
// control register fields and reset values
// --------------------------------------------------------------------
`define SIL_CT_BCAST_BIT    0
`define SIL_CT_BCAST_RST    1'b0

// --------------------------------------------------------------------
// mode decode register fields
// --------------------------------------------------------------------
`define SIL_MD_RGMII_BIT    0
`define SIL_MD_ADV1000F_BIT 1
`define SIL_MD_ADV1000H_BIT 2
`define SIL_MD_ADV100F_BIT  3
`define SIL_MD_ADV100H_BIT  4
`define SIL_MD_WAKEA_BIT    5
`define SIL_MD_WAKEB_BIT    6
`define SIL_MD_NAND_BIT     7
`define SIL_MD_PWRDN_BIT    8
`define SIL_MD_RESV_BIT     9

// --------------------------------------------------------------------
// mode strap codes
// --------------------------------------------------------------------
`define SIL_MODE_RGMII_A    4'h8
`define SIL_MODE_RGMII_B    4'ha
`define SIL_MODE_RGMII_G    4'hc
`define SIL_MODE_RGMII_E    4'he
`define SIL_MODE_NAND       4'h4
`define SIL_MODE_PWRDN      4'h7

// --------------------------------------------------------------------
// reset values of the latched straps and upper address bits
// --------------------------------------------------------------------
`define SIL_ADDR_HI         2'b00
`define SIL_ADDR_RST        3'h0
`define SIL_MODE_RST        4'h0

// --------------------------------------------------------------------
// timing
// --------------------------------------------------------------------
`define SIL_CLK_PERIOD_NS   100
`define SIL_SETTLE_NS       400
`define SIL_SETTLE_CYC      ((`SIL_SETTLE_NS + `SIL_CLK_PERIOD_NS - 1) / `SIL_CLK_PERIOD_NS)

`endif

/* verilog/sil_pkg.sv */
// types of the strap input latch
package sil_pkg;

  // --------------------------------------------------------------------
  // capture sequencer states
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    SIL_ST_FILL,
    SIL_ST_WAIT,
    SIL_ST_HOLD
  } sil_state_t;

  // --------------------------------------------------------------------
  // one set of strap levels
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [2:0] addr;
    logic       bcast;
    logic [3:0] mode;
    logic       refclk_en;
    logic       led_style;
  } sil_straps_t;

endpackage

/* verilog/sil_mode_if.sv */
// decoded device mode carried from the decoder to the top
`timescale 1ns/1ps

interface sil_mode_if;
  logic rgmii;
  logic adv_1000_fd;
  logic adv_1000_hd;
  logic adv_10_100_fd;
  logic adv_10_100_hd;
  logic wake_a_en;
  logic wake_b_en;
  logic nand_tree;
  logic power_down;
  logic reserved;

  modport drv (
    output rgmii,
    output adv_1000_fd,
    output adv_1000_hd,
    output adv_10_100_fd,
    output adv_10_100_hd,
    output wake_a_en,
    output wake_b_en,
    output nand_tree,
    output power_down,
    output reserved
  );

  modport mon (
    input  rgmii,
    input  adv_1000_fd,
    input  adv_1000_hd,
    input  adv_10_100_fd,
    input  adv_10_100_hd,
    input  wake_a_en,
    input  wake_b_en,
    input  nand_tree,
    input  power_down,
    input  reserved
  );
endinterface

/* verilog/sil_sync.sv */
// three-flop pin synchroniser with agreement filter
`timescale 1ns/1ps

module sil_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q,
  output logic              stable
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // --------------------------------------------------------------------
  // chain; s1 feeds s2 only
  // --------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end
    else
    begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // --------------------------------------------------------------------
  // a bit changes only once stages two and three agree
  // --------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= '0;
    else
      for (int i = 0; i < W; i++)
        if (s2_r[i] == s3_r[i])
          q[i] <= s3_r[i];
  end

  assign stable = (s2_r == s3_r);

endmodule

/* verilog/sil_mode_dec.sv */
// registered decode of the latched device mode
`timescale 1ns/1ps
`include "sil_cfg.svh"

module sil_mode_dec (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       valid,
  input  wire logic [3:0] mode,
  sil_mode_if.drv         dec
);

  // --------------------------------------------------------------------
  // mode table; nothing asserted until the straps are latched
  // --------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dec.rgmii         <= 1'b0;
      dec.adv_1000_fd   <= 1'b0;
      dec.adv_1000_hd   <= 1'b0;
      dec.adv_10_100_fd <= 1'b0;
      dec.adv_10_100_hd <= 1'b0;
      dec.wake_a_en     <= 1'b0;
      dec.wake_b_en     <= 1'b0;
      dec.nand_tree     <= 1'b0;
      dec.power_down    <= 1'b0;
      dec.reserved      <= 1'b0;
    end
    else
    begin
      dec.rgmii         <= 1'b0;
      dec.adv_1000_fd   <= 1'b0;
      dec.adv_1000_hd   <= 1'b0;
      dec.adv_10_100_fd <= 1'b0;
      dec.adv_10_100_hd <= 1'b0;
      dec.wake_a_en     <= 1'b0;
      dec.wake_b_en     <= 1'b0;
      dec.nand_tree     <= 1'b0;
      dec.power_down    <= 1'b0;
      dec.reserved      <= 1'b0;
      if (valid)
      begin
        // half duplex at 1000 is never advertised
        unique case (mode)
          `SIL_MODE_RGMII_A, `SIL_MODE_RGMII_B, `SIL_MODE_RGMII_E:
          begin
            dec.rgmii         <= 1'b1; // R10
            dec.adv_1000_fd   <= 1'b1;
            dec.adv_10_100_fd <= 1'b1;
            dec.adv_10_100_hd <= 1'b1;
            dec.wake_a_en     <= (mode == `SIL_MODE_RGMII_A);
            dec.wake_b_en     <= (mode == `SIL_MODE_RGMII_B);
          end
          `SIL_MODE_RGMII_G:
          begin
            dec.rgmii       <= 1'b1; // R10
            dec.adv_1000_fd <= 1'b1;
          end
          `SIL_MODE_NAND:  dec.nand_tree  <= 1'b1; // R11
          `SIL_MODE_PWRDN: dec.power_down <= 1'b1; // R11
          default:         dec.reserved   <= 1'b1; // R11
        endcase
      end
    end
  end

endmodule

/* verilog/sil_strap_latch.sv */
// strap input latch: samples board straps after reset, apb status/control
`timescale 1ns/1ps
`include "sil_cfg.svh"

// Overview of operation
// R1: latch three low address straps, 0..7
// R2: upper two address bits forced zero
// R3: latch broadcast-address strap, selects address-0 response
// R4: broadcast respond enable loads inverted strap
// R5: latch four mode straps, select mode
// R6: latch refclk enable strap, gate clock output
// R7: enabled 125 MHz clock offered to MAC
// R8: latch led style strap, 1 individual
// R9: capture all straps at reset release
// R10: decode four rgmii modes and advertisement
// R11: decode nand tree, power down, reserved
// R12: hold latched values until next reset
module sil_strap_latch #(
  parameter int ADDR_W = 8
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [2:0]        mgmt_addr_strap,
  input  wire logic              bcast_addr_strap,
  input  wire logic [3:0]        mode_strap,
  input  wire logic              refclk_out_en_strap,
  input  wire logic              led_style_strap,
  input  wire logic              refclk_125,
  output logic      [4:0]        mgmt_addr,
  output logic                   bcast_addr_respond_en,
  output logic      [3:0]        mode_sel,
  output logic                   rgmii_mode,
  output logic                   adv_1000_fd,
  output logic                   adv_1000_hd,
  output logic                   adv_10_100_fd,
  output logic                   adv_10_100_hd,
  output logic                   wake_event_out_a_en,
  output logic                   wake_event_out_b_en,
  output logic                   nand_tree_mode,
  output logic                   power_down_mode,
  output logic                   mode_reserved,
  output logic                   refclk_out_en,
  output logic                   refclk_out_pin,
  output logic                   led_individual,
  output logic                   straps_latched
);

  localparam int SW = $bits(sil_pkg::sil_straps_t);
  localparam logic [2:0] SETTLE_CYC = 3'(`SIL_SETTLE_CYC);

  // --------------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------------
  sil_pkg::sil_straps_t pins;
  sil_pkg::sil_straps_t pins_sync;
  sil_pkg::sil_straps_t straps_r;
  sil_pkg::sil_state_t  state_r;
  logic [SW-1:0]        pins_q;
  logic                 pins_stable;
  logic                 stable_d_r;
  logic [2:0]           settle_r;
  logic                 capture;
  logic                 bcast_en_r;
  logic                 wr_en;
  logic                 setup;
  logic                 addr_hit;
  logic [31:0]          rd_nxt;
  logic [31:0]          status_word;
  logic [31:0]          mode_word;

  sil_mode_if mode_if ();

  // --------------------------------------------------------------------
  // strap pins are asynchronous to pclk
  // --------------------------------------------------------------------
  always_comb
  begin
    pins.addr      = mgmt_addr_strap;
    pins.bcast     = bcast_addr_strap;
    pins.mode      = mode_strap;
    pins.refclk_en = refclk_out_en_strap;
    pins.led_style = led_style_strap;
  end

  sil_sync #(
    .W      (SW)
  ) u_sync (
    .clk    (pclk),
    .rst_n  (presetn),
    .d      (pins),
    .q      (pins_q),
    .stable (pins_stable)
  );

  assign pins_sync = sil_pkg::sil_straps_t'(pins_q);

  // q trails the agreeing stages by one edge, so the
  // capture waits for a second agreeing edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stable_d_r <= 1'b0;
    else
      stable_d_r <= pins_stable;
  end

  // --------------------------------------------------------------------
  // capture sequencer
  // --------------------------------------------------------------------
  // flops cannot load pins under async reset, so the capture happens
  // once the synchroniser has refilled after release
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      settle_r <= '0;
    else if (state_r == sil_pkg::SIL_ST_FILL)
      settle_r <= settle_r + 3'h1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_r <= sil_pkg::SIL_ST_FILL;
    else
    begin
      unique case (state_r)
        sil_pkg::SIL_ST_FILL:
          if (settle_r == SETTLE_CYC - 3'h1)
            state_r <= sil_pkg::SIL_ST_WAIT;
        // a pin still moving delays the capture
        sil_pkg::SIL_ST_WAIT:
          if (capture)
            state_r <= sil_pkg::SIL_ST_HOLD; // R9
        sil_pkg::SIL_ST_HOLD:
          state_r <= sil_pkg::SIL_ST_HOLD; // R12
        // code 11 is unused; start over
        default:
          state_r <= sil_pkg::SIL_ST_FILL;
      endcase
    end
  end

  assign capture = (state_r == sil_pkg::SIL_ST_WAIT) && pins_stable
                   && stable_d_r; // R9

  // --------------------------------------------------------------------
  // latched straps, frozen after capture
  // --------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      straps_r.addr      <= `SIL_ADDR_RST;
      straps_r.bcast     <= 1'b1;
      straps_r.mode      <= `SIL_MODE_RST;
      straps_r.refclk_en <= 1'b0;
      straps_r.led_style <= 1'b0;
    end
    else if (capture)
    begin
      straps_r.addr      <= pins_sync.addr; // R1
      straps_r.bcast     <= pins_sync.bcast; // R3
      straps_r.mode      <= pins_sync.mode; // R5
      straps_r.refclk_en <= pins_sync.refclk_en; // R6
      straps_r.led_style <= pins_sync.led_style; // R8
    end
  end

  assign straps_latched = (state_r == sil_pkg::SIL_ST_HOLD);

  // --------------------------------------------------------------------
  // settings offered to the rest of the chip
  // --------------------------------------------------------------------
  assign mgmt_addr      = {`SIL_ADDR_HI, straps_r.addr}; // R1 R2
  assign mode_sel       = straps_r.mode; // R5
  assign refclk_out_en  = straps_r.refclk_en; // R6
  assign led_individual = straps_r.led_style; // R8

  // enable is static after capture, so the and-gate cannot chop a pulse
  // except at the single capture edge
  assign refclk_out_pin = refclk_125 & straps_r.refclk_en; // R6 R7

  // --------------------------------------------------------------------
  // mode decode
  // --------------------------------------------------------------------
  sil_mode_dec u_dec (
    .pclk    (pclk),
    .presetn (presetn),
    .valid   (straps_latched),
    .mode    (straps_r.mode),
    .dec     (mode_if)
  );

  assign rgmii_mode          = mode_if.rgmii; // R10
  assign adv_1000_fd         = mode_if.adv_1000_fd;
  assign adv_1000_hd         = mode_if.adv_1000_hd;
  assign adv_10_100_fd       = mode_if.adv_10_100_fd;
  assign adv_10_100_hd       = mode_if.adv_10_100_hd;
  assign wake_event_out_a_en = mode_if.wake_a_en;
  assign wake_event_out_b_en = mode_if.wake_b_en;
  assign nand_tree_mode      = mode_if.nand_tree; // R11
  assign power_down_mode     = mode_if.power_down;
  assign mode_reserved       = mode_if.reserved;

  // --------------------------------------------------------------------
  // apb slave, zero wait states
  // --------------------------------------------------------------------
  assign pready = 1'b1;
  assign setup  = psel && !penable;
  assign wr_en  = psel && penable && pwrite && pready
                  && (paddr == `SIL_OFS_CTRL) && pstrb[0];

  // --------------------------------------------------------------------
  // broadcast respond enable; capture load wins over a software write
  // --------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      bcast_en_r <= `SIL_CT_BCAST_RST;
    else if (capture)
      bcast_en_r <= ~pins_sync.bcast; // R4
    else if (wr_en)
      bcast_en_r <= pwdata[`SIL_CT_BCAST_BIT];
  end

  // response to address 0 in addition to its own address
  assign bcast_addr_respond_en = bcast_en_r; // R3

  // --------------------------------------------------------------------
  // read words
  // --------------------------------------------------------------------
  always_comb
  begin
    status_word = '0;
    status_word[`SIL_ST_ADDR_LSB +: 5] = mgmt_addr;
    status_word[`SIL_ST_BCAST_BIT]     = straps_r.bcast;
    status_word[`SIL_ST_MODE_LSB +: 4] = straps_r.mode;
    status_word[`SIL_ST_REFCLK_BIT]    = straps_r.refclk_en;
    status_word[`SIL_ST_LED_BIT]       = straps_r.led_style;
    status_word[`SIL_ST_DONE_BIT]      = straps_latched;
  end

  always_comb
  begin
    mode_word = '0;
    mode_word[`SIL_MD_RGMII_BIT]    = mode_if.rgmii;
    mode_word[`SIL_MD_ADV1000F_BIT] = mode_if.adv_1000_fd;
    mode_word[`SIL_MD_ADV1000H_BIT] = mode_if.adv_1000_hd;
    mode_word[`SIL_MD_ADV100F_BIT]  = mode_if.adv_10_100_fd;
    mode_word[`SIL_MD_ADV100H_BIT]  = mode_if.adv_10_100_hd;
    mode_word[`SIL_MD_WAKEA_BIT]    = mode_if.wake_a_en;
    mode_word[`SIL_MD_WAKEB_BIT]    = mode_if.wake_b_en;
    mode_word[`SIL_MD_NAND_BIT]     = mode_if.nand_tree;
    mode_word[`SIL_MD_PWRDN_BIT]    = mode_if.power_down;
    mode_word[`SIL_MD_RESV_BIT]     = mode_if.reserved;
  end

  always_comb
  begin
    rd_nxt   = '0;
    addr_hit = 1'b1;
    unique case (paddr)
      `SIL_OFS_STATUS: rd_nxt = status_word;
      `SIL_OFS_CTRL:   rd_nxt[`SIL_CT_BCAST_BIT] = bcast_en_r;
      `SIL_OFS_MODE:   rd_nxt = mode_word;
      default:         addr_hit = 1'b0;
    endcase
  end

  // --------------------------------------------------------------------
  // read data and error sampled in setup, held through access
  // --------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= '0;
    else if (setup)
      prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pslverr <= 1'b0;
    else if (setup)
      pslverr <= !addr_hit;
    else if (!psel)
      pslverr <= 1'b0;
  end

endmodule

/* test/sil_strap_monitor.sv */
// assertion checker bound to the strap input latch
`timescale 1ns/1ps

module sil_strap_monitor (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic [2:0] mgmt_addr_strap,
  input wire logic       bcast_addr_strap,
  input wire logic [3:0] mode_strap,
  input wire logic       refclk_out_en_strap,
  input wire logic       led_style_strap,
  input wire logic       refclk_125,
  input wire logic [4:0] mgmt_addr,
  input wire logic       bcast_addr_respond_en,
  input wire logic [3:0] mode_sel,
  input wire logic       rgmii_mode,
  input wire logic       adv_1000_fd,
  input wire logic       adv_1000_hd,
  input wire logic       adv_10_100_fd,
  input wire logic       adv_10_100_hd,
  input wire logic       wake_event_out_a_en,
  input wire logic       wake_event_out_b_en,
  input wire logic       nand_tree_mode,
  input wire logic       power_down_mode,
  input wire logic       mode_reserved,
  input wire logic       refclk_out_en,
  input wire logic       refclk_out_pin,
  input wire logic       led_individual,
  input wire logic       straps_latched
);
  // --------------------------------------------------------------------
  // properties
  // --------------------------------------------------------------------
  default clocking mon_cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // pins must stay static around capture, else $past sees a moving value
  addr_capture_a: assert property ($rose(straps_latched) |->
    mgmt_addr[2:0] == $past(mgmt_addr_strap)) else $error("address differs from straps");
  addr_upper_a: assert property (mgmt_addr[4:3] == 2'b00)
    else $error("upper address bits not zero");
  bcast_capture_a: assert property ($rose(straps_latched) |->
    bcast_addr_respond_en == !$past(bcast_addr_strap)) else $error("respond enable wrong");
  mode_capture_a: assert property ($rose(straps_latched) |->
    mode_sel == $past(mode_strap)) else $error("mode differs from straps");
  clk_led_capture_a: assert property ($rose(straps_latched) |->
    refclk_out_en == $past(refclk_out_en_strap) && led_individual == $past(led_style_strap))
    else $error("clock enable or led style wrong");
  refclk_gate_a: assert property (refclk_out_pin == (refclk_125 && refclk_out_en))
    else $error("reference clock output not gated by enable");
  capture_time_a: assert property ($rose(presetn) |->
    !straps_latched [*3] ##[1:10] straps_latched) else $error("capture too early or late");
  rgmii_dec_a: assert property (straps_latched && $past(straps_latched) |->
    rgmii_mode == (mode_sel inside {4'h8, 4'ha, 4'hc, 4'he}) && adv_1000_fd == rgmii_mode
    && !adv_1000_hd && adv_10_100_fd == (rgmii_mode && mode_sel != 4'hc)
    && adv_10_100_hd == adv_10_100_fd && wake_event_out_a_en == (mode_sel == 4'h8)
    && wake_event_out_b_en == (mode_sel == 4'ha))
    else $error("rgmii decode wrong");
  test_dec_a: assert property (straps_latched && $past(straps_latched) |->
    nand_tree_mode == (mode_sel == 4'h4) && power_down_mode == (mode_sel == 4'h7)
    && mode_reserved == !(rgmii_mode || nand_tree_mode || power_down_mode))
    else $error("test mode decode wrong");
  latch_hold_a: assert property (straps_latched && $past(straps_latched) |->
    $stable({mgmt_addr, mode_sel, refclk_out_en, led_individual})) else $error("latch moved");
endmodule

bind sil_strap_latch sil_strap_monitor sil_strap_monitor_i (
  .pclk, .presetn, .mgmt_addr_strap, .bcast_addr_strap, .mode_strap, .refclk_out_en_strap,
  .led_style_strap, .refclk_125, .mgmt_addr, .bcast_addr_respond_en, .mode_sel, .rgmii_mode,
  .adv_1000_fd, .adv_1000_hd, .adv_10_100_fd, .adv_10_100_hd, .nand_tree_mode, .power_down_mode,
  .wake_event_out_a_en, .wake_event_out_b_en,
  .mode_reserved, .refclk_out_en, .refclk_out_pin, .led_individual, .straps_latched
);

/* test/sil_board.sv */
// board model: strap resistors and a free running 125 MHz source
`timescale 1ns/1ps

module sil_board (
  input  wire sil_pkg::sil_straps_t cfg,
  output logic [2:0]                mgmt_addr_strap,
  output logic                      bcast_addr_strap,
  output logic [3:0]                mode_strap,
  output logic                      refclk_out_en_strap,
  output logic                      led_style_strap,
  output logic                      refclk_125
);
  assign mgmt_addr_strap = cfg.addr;
  assign bcast_addr_strap = cfg.bcast;
  assign mode_strap = cfg.mode;
  assign refclk_out_en_strap = cfg.refclk_en;
  assign led_style_strap = cfg.led_style;
  initial refclk_125 = 1'b0;
  always #4 refclk_125 = ~refclk_125;
endmodule

/* test/sil_strap_latch_bench.sv */
// self-checking bench of the strap input latch
`timescale 1ns/1ps
`include "sil_cfg.svh"

module sil_strap_latch_bench;
  logic                 pclk;
  logic                 presetn;
  logic [7:0]           paddr;
  logic                 psel;
  logic                 penable;
  logic                 pwrite;
  logic [31:0]          pwdata;
  logic [3:0]           pstrb;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  sil_pkg::sil_straps_t cfg;
  logic [2:0]           mgmt_addr_strap;
  logic                 bcast_addr_strap;
  logic [3:0]           mode_strap;
  logic                 refclk_out_en_strap;
  logic                 led_style_strap;
  logic                 refclk_125;
  logic [4:0]           mgmt_addr;
  logic                 bcast_addr_respond_en;
  logic                 refclk_out_en;
  logic                 led_individual;
  logic                 straps_latched;
  logic [31:0]          rd;
  logic                 err;
  int                   failures;
  int                   checks;

  sil_board sil_board_i (.cfg, .mgmt_addr_strap, .bcast_addr_strap, .mode_strap,
    .refclk_out_en_strap, .led_style_strap, .refclk_125);
  sil_strap_latch sil_strap_latch_i (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .mgmt_addr_strap, .bcast_addr_strap,
    .mode_strap, .refclk_out_en_strap, .led_style_strap, .refclk_125, .mgmt_addr,
    .bcast_addr_respond_en, .mode_sel(), .rgmii_mode(), .adv_1000_fd(), .adv_1000_hd(),
    .adv_10_100_fd(), .adv_10_100_hd(), .wake_event_out_a_en(), .wake_event_out_b_en(),
    .nand_tree_mode(), .power_down_mode(), .mode_reserved(), .refclk_out_en,
    .refclk_out_pin(), .led_individual, .straps_latched);

  initial pclk = 1'b0;
  always #50 pclk = ~pclk;

  // --------------------------------------------------------------------
  // reporting, bus cycles, expectations
  // --------------------------------------------------------------------
  task automatic summarize;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic timeout(input string what);
    failures++;
    $display("mismatch at %0t: timeout on %s", $time, what);
    summarize();
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
      timeout("bus");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic restart(input sil_pkg::sil_straps_t c);
    int n;
    presetn <= 1'b0;
    cfg <= c;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    n = 0;
    while (straps_latched !== 1'b1 && n < 30)
    begin
      @(posedge pclk);
      n++;
    end
    if (straps_latched !== 1'b1)
      timeout("capture");
    @(posedge pclk);
  endtask

  function automatic logic [31:0] exp_status(input sil_pkg::sil_straps_t c);
    exp_status = {1'b1, 19'h0, c.led_style, c.refclk_en, c.mode, c.bcast, 2'b00, c.addr};
  endfunction

  function automatic logic [31:0] exp_mode(input logic [3:0] m);
    logic r;
    logic lo;
    r = m inside {4'h8, 4'ha, 4'hc, 4'he};
    lo = r && m != 4'hc;
    exp_mode = {22'h0, !(r || m == 4'h4 || m == 4'h7), m == 4'h7, m == 4'h4,
                m == 4'ha, m == 4'h8, lo, lo, 1'b0, r, r};
  endfunction

  // --------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------
  initial
  begin
    sil_pkg::sil_straps_t c;
    failures = 0;
    checks = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    cfg = '0;
    rd = $urandom(32'hee0b7024);
    for (int i = 0; i < 16; i++)
    begin
      rd = $urandom;
      c = rd[9:0];
      c.mode = i[3:0];
      if (i < 2)
        c.addr = {3{i == 0}};
      restart(c);
      apb(1'b0, `SIL_OFS_STATUS, 32'h0, 4'h0);
      check(rd, exp_status(c), "status");
      apb(1'b0, `SIL_OFS_MODE, 32'h0, 4'h0);
      check(rd, exp_mode(c.mode), "mode decode");
      apb(1'b0, `SIL_OFS_CTRL, 32'h0, 4'h0);
      check(rd, {31'h0, !c.bcast}, "respond enable");
      check({27'h0, mgmt_addr}, {29'h0, c.addr}, "address port");
      check({30'h0, refclk_out_en, led_individual}, {30'h0, c.refclk_en, c.led_style},
            "clock and led ports");
      // pins wander after capture; nothing latched may follow them
      rd = $urandom;
      cfg <= rd[9:0];
      repeat (6) @(posedge pclk);
      apb(1'b0, `SIL_OFS_STATUS, 32'h0, 4'h0);
      check(rd, exp_status(c), "held status");
    end
    apb(1'b1, `SIL_OFS_CTRL, {31'h0, c.bcast}, 4'h0);
    apb(1'b0, `SIL_OFS_CTRL, 32'h0, 4'h0);
    check(rd, {31'h0, !c.bcast}, "write without strobe");
    apb(1'b1, `SIL_OFS_CTRL, {31'h0, c.bcast}, 4'h1);
    apb(1'b0, `SIL_OFS_CTRL, 32'h0, 4'h0);
    check(rd, {31'h0, c.bcast}, "respond enable written");
    check({31'h0, bcast_addr_respond_en}, {31'h0, c.bcast}, "respond port");
    apb(1'b1, `SIL_OFS_STATUS, 32'hffffffff, 4'hf);
    apb(1'b0, `SIL_OFS_STATUS, 32'h0, 4'h0);
    check(rd, exp_status(c), "status write ignored");
    apb(1'b0, 8'h0c, 32'h0, 4'h0);
    check({rd[30:0], err}, 32'h1, "unmapped read");
    summarize();
  end
endmodule
